// ### sysq_sequencer.v
// Reset, stop recovery and bus clock sequencer
`include "sysq_defines.vh"

module sysq_sequencer #(
    parameter NUM_PERIPH      = 4,
    parameter WD_BITS         = 6,
    parameter PIN_SHORT_CYC   = `SQ_PIN_SHORT_CYC,
    parameter PIN_LONG_CYC    = `SQ_PIN_LONG_CYC
) (
    input  wire                  sys_clk,
    input  wire                  reset_n,
    input  wire                  powerOnPulse,
    input  wire                  resetPin_n,
    input  wire                  lowVoltageDetect,
    input  wire                  lvPowerDisable,
    input  wire                  lvResetDisable,
    input  wire                  badOpcode,
    input  wire                  stopExec,
    input  wire                  waitExec,
    input  wire                  stopPermit,
    input  wire                  shortStopRecovery,
    input  wire                  stopOscKeep,
    input  wire                  wakeRequest,
    input  wire                  opcodeFetch,
    input  wire                  unmappedAddr,
    input  wire                  vectorFetch,
    input  wire [7:0]            vectorData,
    input  wire                  topAddrWrite,
    input  wire                  irqHighVoltage,
    input  wire                  monitorStrap,
    input  wire [NUM_PERIPH-1:0] periphWaitRun,
    output reg                   genClockOut_r,
    output reg                   genClockEnable_r,
    output reg                   busClock_r,
    output reg                   cpuClock_r,
    output reg  [NUM_PERIPH-1:0] periphClock_r,
    output reg                   internalReset_r,
    output reg  [15:0]           resetVector_r,
    output reg                   monitorMode_r,
    output reg  [7:0]            resetStatus_r
);

    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [6:0] ST_HOLD  = 7'h01;
    localparam [6:0] ST_STAB  = 7'h02;
    localparam [6:0] ST_VEC   = 7'h04;
    localparam [6:0] ST_RUN   = 7'h08;
    localparam [6:0] ST_STOP  = 7'h10;
    localparam [6:0] ST_RECOV = 7'h20;
    localparam [6:0] ST_WAIT  = 7'h40;

    localparam [12:0] PIN_SHORT_LAST = PIN_SHORT_CYC[12:0] - 13'h0001;
    localparam [12:0] PIN_LONG_LAST  = PIN_LONG_CYC[12:0] - 13'h0001;

    reg  [6:0]  state_r;
    reg  [6:0]  state_nxt;
    reg         seqClr_r;
    reg         seqClr_nxt;
    reg         longSrc_r;
    reg         shortSel_r;
    reg         menPending_r;
    reg  [12:0] pinCnt_r;
    reg  [1:0]  divCnt_r;
    reg  [7:0]  status_nxt;
    reg  [11:0] phaseLast;
    reg         monitor_nxt;

    wire [11:0] seqCount;
    wire        seqOverflow;
    wire        wdTimeout;
    wire [1:0]  divCnt_nxt;
    wire        busRun;

    // ----------------------------------------
    // Reset sources
    // ----------------------------------------
    wire inRun      = (state_r == ST_RUN);
    wire pinLow     = ~resetPin_n;
    wire lviEvent   = lowVoltageDetect & ~lvPowerDisable & ~lvResetDisable;
    wire stopIll    = inRun & stopExec & ~stopPermit;
    wire ilopEvent  = (inRun & badOpcode) | stopIll;
    wire iladEvent  = inRun & opcodeFetch & unmappedAddr;
    wire menEvent   = ~internalReset_r & vectorFetch & (vectorData == 8'h00);
    wire copEvent   = wdTimeout;
    wire longEvent  = powerOnPulse | lviEvent;
    wire anyEvent   = longEvent | copEvent | ilopEvent | iladEvent | menEvent | pinLow;
    wire pinLong    = longSrc_r | longEvent;
    wire phaseDone  = ~seqClr_r & (seqCount == phaseLast);
    wire wdService  = topAddrWrite & (inRun | (state_r == ST_WAIT));
    wire wdDisable  = irqHighVoltage & monitorMode_r;

    // ----------------------------------------
    // Counters
    // ----------------------------------------
    sysq_seq_counter #(
        .WIDTH      (12)
    ) u_seqCounter (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .clearAll   (seqClr_r),
        .clearHigh  (wdService),
        .count_r    (seqCount),
        .overflow_r (seqOverflow)
    );

    sysq_watchdog #(
        .WD_BITS    (WD_BITS)
    ) u_watchdog (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .tick       (seqOverflow),
        .clear      (wdService | internalReset_r),
        .wdDisable  (wdDisable),
        .timeout_r  (wdTimeout)
    );

    // ----------------------------------------
    // Phase length
    // ----------------------------------------
    always @* begin
        phaseLast = `SQ_STAB_LAST;
        if (state_r == ST_VEC) begin
            phaseLast = `SQ_VEC_LAST;
        end else if (state_r == ST_RECOV && shortSel_r) begin
            phaseLast = `SQ_SHORT_LAST;
        end
    end

    // ----------------------------------------
    // State machine
    // ----------------------------------------
    always @* begin
        state_nxt = state_r;
        if (anyEvent) begin
            state_nxt = ST_HOLD;
        end else begin
            case (state_r)
                ST_HOLD: begin
                    state_nxt = longSrc_r ? ST_STAB : ST_VEC;
                end
                ST_STAB: begin
                    if (phaseDone) begin
                        state_nxt = ST_VEC;
                    end
                end
                ST_VEC: begin
                    if (phaseDone) begin
                        state_nxt = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (stopExec && stopPermit) begin
                        state_nxt = ST_STOP;
                    end else if (waitExec) begin
                        state_nxt = ST_WAIT;
                    end
                end
                ST_STOP: begin
                    if (wakeRequest) begin
                        state_nxt = ST_RECOV;
                    end
                end
                ST_RECOV: begin
                    if (phaseDone) begin
                        state_nxt = ST_RUN;
                    end
                end
                ST_WAIT: begin
                    if (wakeRequest) begin
                        state_nxt = ST_RUN;
                    end
                end
                default: begin
                    state_nxt = ST_HOLD;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Counter clear
    // ----------------------------------------
    always @* begin
        seqClr_nxt = (state_nxt == ST_HOLD) || (state_nxt == ST_STOP);
        if (state_nxt != state_r) begin
            if (state_nxt == ST_STAB || state_nxt == ST_VEC || state_nxt == ST_RECOV) begin
                seqClr_nxt = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Reset status
    // ----------------------------------------
    always @* begin
        status_nxt = resetStatus_r;
        if (powerOnPulse) begin
            status_nxt = `SQ_STATUS_RST;
            status_nxt[`SQ_ST_POR] = 1'b1;
        end else begin
            if (copEvent) begin
                status_nxt[`SQ_ST_WDOG] = 1'b1;
            end
            if (ilopEvent) begin
                status_nxt[`SQ_ST_BADOP] = 1'b1;
            end
            if (iladEvent) begin
                status_nxt[`SQ_ST_BADADDR] = 1'b1;
            end
            if (menEvent) begin
                status_nxt[`SQ_ST_ERASED] = 1'b1;
            end
            if (lviEvent) begin
                status_nxt[`SQ_ST_LOWV] = 1'b1;
            end
            if (pinLow && pinCnt_r == (pinLong ? PIN_LONG_LAST : PIN_SHORT_LAST)) begin
                status_nxt[`SQ_ST_PIN] = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Monitor mode selection
    // ----------------------------------------
    always @* begin
        monitor_nxt = monitorMode_r;
        if (state_r == ST_VEC && state_nxt == ST_RUN) begin
            monitor_nxt = monitorStrap | menPending_r;
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r       <= ST_HOLD;
            seqClr_r      <= 1'b1;
            longSrc_r     <= 1'b1;
            shortSel_r    <= 1'b0;
            menPending_r  <= 1'b0;
            pinCnt_r      <= 13'h0000;
            resetStatus_r <= `SQ_STATUS_RST;
            monitorMode_r <= 1'b0;
            resetVector_r <= `SQ_VEC_NORMAL;
        end else begin
            state_r       <= state_nxt;
            seqClr_r      <= seqClr_nxt;
            resetStatus_r <= status_nxt;
            monitorMode_r <= monitor_nxt;
            resetVector_r <= monitor_nxt ? `SQ_VEC_MONITOR : `SQ_VEC_NORMAL;
            if (longEvent || (anyEvent && state_r == ST_STOP)) begin
                longSrc_r <= 1'b1;
            end else if (state_r == ST_VEC) begin
                longSrc_r <= 1'b0;
            end
            if (state_r == ST_STOP && wakeRequest) begin
                shortSel_r <= shortStopRecovery & ~anyEvent;
            end
            if (menEvent) begin
                menPending_r <= 1'b1;
            end else if (state_r == ST_VEC && state_nxt == ST_RUN) begin
                menPending_r <= 1'b0;
            end
            if (!pinLow) begin
                pinCnt_r <= 13'h0000;
            end else if (pinCnt_r != 13'h1FFF) begin
                pinCnt_r <= pinCnt_r + 13'h0001;
            end
        end
    end

    // ----------------------------------------
    // Clock generation
    // ----------------------------------------
    assign divCnt_nxt = divCnt_r + 2'h1;
    assign busRun     = (state_nxt == ST_RUN) || (state_nxt == ST_WAIT);

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            divCnt_r         <= 2'h0;
            genClockOut_r    <= 1'b0;
            genClockEnable_r <= 1'b1;
            busClock_r       <= 1'b0;
            cpuClock_r       <= 1'b0;
            internalReset_r  <= 1'b1;
        end else begin
            divCnt_r         <= divCnt_nxt;
            genClockEnable_r <= ~((state_nxt == ST_STOP) & ~stopOscKeep);
            genClockOut_r    <= genClockEnable_r ? divCnt_nxt[0] : 1'b0;
            busClock_r       <= busRun & divCnt_nxt[1];
            cpuClock_r       <= (state_nxt == ST_RUN) & divCnt_nxt[1];
            internalReset_r  <= (state_nxt == ST_HOLD) || (state_nxt == ST_STAB) ||
                                (state_nxt == ST_VEC);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PERIPH; gi = gi + 1) begin : g_periph
            always @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    periphClock_r[gi] <= 1'b0;
                end else begin
                    periphClock_r[gi] <= ((state_nxt == ST_RUN) ||
                                          ((state_nxt == ST_WAIT) && periphWaitRun[gi])) &
                                         divCnt_nxt[1];
                end
            end
        end
    endgenerate

endmodule // sysq_sequencer

// ### sysq_defines.vh
// Shared constants of the reset and clock sequencer
`ifndef SYSQ_DEFINES_VH
`define SYSQ_DEFINES_VH

// ----------------------------------------
// Sequencing counter phase ends
// ----------------------------------------
`define SQ_STAB_LAST        12'hFFF
`define SQ_VEC_LAST         12'h03F
`define SQ_SHORT_LAST       12'h01F

// ----------------------------------------
// Pin reset qualification
// ----------------------------------------
`define SQ_PIN_SHORT_CYC    67
`define SQ_PIN_LONG_CYC     4163

// ----------------------------------------
// Reset vectors
// ----------------------------------------
`define SQ_VEC_NORMAL       16'hFFFE
`define SQ_VEC_MONITOR      16'hFEFE

// ----------------------------------------
// Reset status bit positions
// ----------------------------------------
`define SQ_ST_POR           7
`define SQ_ST_PIN           6
`define SQ_ST_WDOG          5
`define SQ_ST_BADOP         4
`define SQ_ST_BADADDR       3
`define SQ_ST_ERASED        2
`define SQ_ST_LOWV          1
`define SQ_STATUS_RST       8'h00

`endif

// ### sysq_seq_counter.v
// Sequencing counter, advanced on the falling clock edge
module sysq_seq_counter #(
    parameter WIDTH = 12
) (
    input  wire             sys_clk,
    input  wire             reset_n,
    input  wire             clearAll,
    input  wire             clearHigh,
    output reg  [WIDTH-1:0] count_r,
    output reg              overflow_r
);

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    // falling edge count
    always @(negedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_r    <= {WIDTH{1'b0}};
            overflow_r <= 1'b0;
        end else if (clearAll) begin
            count_r    <= {WIDTH{1'b0}};
            overflow_r <= 1'b0;
        end else if (clearHigh) begin
            count_r    <= {{(WIDTH-4){1'b0}}, count_r[3:0]};
            overflow_r <= 1'b0;
        end else begin
            count_r    <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
            overflow_r <= &count_r;
        end
    end

endmodule // sysq_seq_counter

// ### sysq_watchdog.v
// Watchdog counter prescaled by the sequencing counter overflow
module sysq_watchdog #(
    parameter WD_BITS = 6
) (
    input  wire sys_clk,
    input  wire reset_n,
    input  wire tick,
    input  wire clear,
    input  wire wdDisable,
    output reg  timeout_r
);

    reg [WD_BITS-1:0] wdCnt_r;

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wdCnt_r   <= {WD_BITS{1'b0}};
            timeout_r <= 1'b0;
        end else if (clear || wdDisable) begin
            wdCnt_r   <= {WD_BITS{1'b0}};
            timeout_r <= 1'b0;
        end else if (tick) begin
            wdCnt_r   <= wdCnt_r + {{(WD_BITS-1){1'b0}}, 1'b1};
            timeout_r <= &wdCnt_r;
        end else begin
            timeout_r <= 1'b0;
        end
    end

endmodule // sysq_watchdog

// ### sysq_seq_asserts.sv
// Assertion checker for the reset and clock sequencer
`include "sysq_defines.vh"
module sysq_seq_asserts #(
    parameter NUM_PERIPH = 4
) (
    input wire                  sys_clk,
    input wire                  reset_n,
    input wire                  powerOnPulse,
    input wire                  resetPin_n,
    input wire                  lowVoltageDetect,
    input wire                  lvPowerDisable,
    input wire                  lvResetDisable,
    input wire                  badOpcode,
    input wire                  stopExec,
    input wire                  stopPermit,
    input wire                  genClockOut_r,
    input wire                  genClockEnable_r,
    input wire                  busClock_r,
    input wire                  cpuClock_r,
    input wire [NUM_PERIPH-1:0] periphClock_r,
    input wire                  internalReset_r,
    input wire [15:0]           resetVector_r,
    input wire                  monitorMode_r,
    input wire [7:0]            resetStatus_r
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    logic [15:0] rstLen_r;
    logic        longSeen_r;
    wire         lvOn = lowVoltageDetect && !lvPowerDisable && !lvResetDisable;
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstLen_r   <= 16'h0000;
            longSeen_r <= 1'b1;
        end else begin
            rstLen_r   <= !internalReset_r ? 16'h0000 : (rstLen_r == 16'hFFFF ? rstLen_r : rstLen_r + 16'h0001);
            longSeen_r <= (powerOnPulse || lvOn) ? 1'b1 : (internalReset_r ? longSeen_r : 1'b0);
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    property p_por_rst; powerOnPulse |=> internalReset_r && genClockEnable_r; endproperty
    property p_por_flags; $fell(powerOnPulse) |-> resetStatus_r == 8'h80; endproperty
    property p_pin_halt; !resetPin_n |=> internalReset_r; endproperty
    property p_gen_div; genClockEnable_r && $past(genClockEnable_r) && $past(genClockEnable_r, 2) && $past(reset_n)
        |-> genClockOut_r != $past(genClockOut_r);
    endproperty
    property p_clk_off; internalReset_r && $past(internalReset_r) |-> !busClock_r && !cpuClock_r
        && periphClock_r == '0; endproperty
    property p_sub_clk; (cpuClock_r || periphClock_r != '0) |-> busClock_r; endproperty
    property p_vec; $fell(internalReset_r) |-> resetVector_r == (monitorMode_r ? `SQ_VEC_MONITOR : `SQ_VEC_NORMAL);
    endproperty
    property p_rel_short; $fell(internalReset_r) |-> rstLen_r >= 16'h003C; endproperty
    property p_rel_long; $fell(internalReset_r) && $past(longSeen_r) |-> rstLen_r >= 16'h1036; endproperty
    property p_badop; (badOpcode || (stopExec && !stopPermit)) && !internalReset_r |-> ##[1:2]
        (internalReset_r && resetStatus_r[`SQ_ST_BADOP]); endproperty
    property p_lv; lvOn |-> ##[1:2] (internalReset_r && resetStatus_r[`SQ_ST_LOWV]); endproperty
    property p_sticky; !$past(powerOnPulse) |-> (resetStatus_r & $past(resetStatus_r)) == $past(resetStatus_r);
    endproperty
    a_por_rst: assert property (p_por_rst) else $error("power-on did not reset");
    a_por_flags: assert property (p_por_flags) else $error("power-on status wrong");
    a_pin_halt: assert property (p_pin_halt) else $error("pin low did not halt");
    a_gen_div: assert property (p_gen_div) else $error("generator clock not halved");
    a_clk_off: assert property (p_clk_off) else $error("clocks run in reset");
    a_sub_clk: assert property (p_sub_clk) else $error("clock outside bus phase");
    a_vec: assert property (p_vec) else $error("vector mismatch");
    a_rel_short: assert property (p_rel_short) else $error("release too early");
    a_rel_long: assert property (p_rel_long) else $error("long release too early");
    a_badop: assert property (p_badop) else $error("bad opcode not reset");
    a_lv: assert property (p_lv) else $error("low voltage not flagged");
    a_sticky: assert property (p_sticky) else $error("status flag lost");
    c_mon: cover property ($fell(internalReset_r) && monitorMode_r);
    c_wdog: cover property ($rose(resetStatus_r[`SQ_ST_WDOG]));
    c_stop: cover property ($fell(genClockEnable_r));
endmodule // sysq_seq_asserts

bind sysq_sequencer sysq_seq_asserts #(.NUM_PERIPH(NUM_PERIPH)) sysq_seq_asserts_i (.sys_clk, .reset_n,
    .powerOnPulse, .resetPin_n, .lowVoltageDetect, .lvPowerDisable, .lvResetDisable, .badOpcode, .stopExec,
    .stopPermit, .genClockOut_r, .genClockEnable_r, .busClock_r, .cpuClock_r, .periphClock_r,
    .internalReset_r, .resetVector_r, .monitorMode_r, .resetStatus_r);

// ### sysq_core_model.sv
// Processor core stand-in that fetches the reset vector
module sysq_core_model (
    input  wire        sys_clk,
    input  wire        internalReset_r,
    input  wire        eraseArm,
    output logic       vectorFetch = 1'b0,
    output logic [7:0] vectorData = 8'h5A
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       rstQ_r = 1'b1;
    logic       pend_r = 1'b0;
    logic [1:0] cnt_r  = 2'h0;
    always @(posedge sys_clk) begin
        rstQ_r      <= internalReset_r;
        cnt_r       <= (rstQ_r && !internalReset_r) ? 2'h2 : (cnt_r != 2'h0 ? cnt_r - 2'h1 : cnt_r);
        vectorFetch <= cnt_r != 2'h0;
        vectorData  <= cnt_r != 2'h0 ? (pend_r ? 8'h00 : 8'h3C) : ~vectorData;
        pend_r      <= eraseArm ? 1'b1 : (cnt_r == 2'h1 ? 1'b0 : pend_r);
    end
endmodule // sysq_core_model

// ### tb_top.sv
// Self-checking testbench of the reset and clock sequencer
`include "sysq_defines.vh"
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin errCount++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0, reset_n = 0, powerOnPulse = 0, resetPin_n = 1, lowVoltageDetect = 0;
    logic lvPowerDisable = 0, lvResetDisable = 0, badOpcode = 0, stopExec = 0, waitExec = 0;
    logic stopPermit = 1, shortStopRecovery = 0, stopOscKeep = 0, wakeRequest = 0, opcodeFetch = 0;
    logic unmappedAddr = 0, topAddrWrite = 0, irqHighVoltage = 0, monitorStrap = 0, eraseArm = 0;
    logic [3:0] periphWaitRun = 0, periphClock_r, perOr;
    logic genClockOut_r, genClockEnable_r, busClock_r, cpuClock_r, internalReset_r, monitorMode_r;
    logic vectorFetch, sawRst = 0, cpuOr, busOr;
    logic [7:0] vectorData, resetStatus_r;
    logic [15:0] resetVector_r;
    logic [8:0] expQ[$];
    int errCount = 0, totalChecks = 0, cyc = 0, n;
    integer seed = 32'hb8cbe118;
    int bitOf[8] = '{`SQ_ST_PIN, `SQ_ST_BADOP, `SQ_ST_BADOP, `SQ_ST_BADADDR, `SQ_ST_LOWV, -1, `SQ_ST_WDOG,
        `SQ_ST_ERASED};

    sysq_sequencer #(.NUM_PERIPH(4), .WD_BITS(1), .PIN_SHORT_CYC(5), .PIN_LONG_CYC(40)) sysq_sequencer_i (.*);
    sysq_core_model sysq_core_model_i (.*);

    always #20 sys_clk = ~sys_clk;
    always @(posedge internalReset_r) sawRst = 1;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 100000) begin
            errCount++;
            $display("MISMATCH %0t run timed out", $time);
            reportAndStop;
        end
    end
    // ----------------------------------------
    // Result watcher at every reset release
    // ----------------------------------------
    always @(negedge internalReset_r) begin
        logic [8:0] e;
        @(negedge sys_clk);
        if (expQ.size() == 0) begin
            errCount++;
            $display("MISMATCH %0t release without note", $time);
        end else begin
            e = expQ.pop_front();
            `CHK(resetStatus_r, e[7:0])
            `CHK(monitorMode_r, e[8])
            `CHK(resetVector_r, e[8] ? `SQ_VEC_MONITOR : `SQ_VEC_NORMAL)
        end
    end
    // ----------------------------------------
    // Drivers
    // ----------------------------------------
    task tick(input int c);
        repeat (c) @(posedge sys_clk);
    endtask
    task waitRst(input logic v, input int lim);
        n = 0;
        while (internalReset_r !== v && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= lim) begin
            errCount++;
            $display("MISMATCH %0t reset level not reached", $time);
        end
    endtask
    task por;
        powerOnPulse <= 1;
        tick(2);
        powerOnPulse <= 0;
        expQ.push_back(9'h080);
        waitRst(0, 6000);
        tick(4);
    endtask
    task fire(input int k);
        case (k)
            0, 5: begin
                resetPin_n <= 0;
                tick(k == 0 ? 10 + ($random(seed) & 7) : 3);
                resetPin_n <= 1;
            end
            1: begin
                badOpcode <= 1;
                tick(1);
                badOpcode <= 0;
            end
            2: begin
                stopPermit <= 0;
                stopExec <= 1;
                tick(1);
                stopExec <= 0;
                stopPermit <= 1;
            end
            3: begin
                opcodeFetch <= 1;
                unmappedAddr <= 1;
                tick(1);
                opcodeFetch <= 0;
                unmappedAddr <= 0;
            end
            4: begin
                lowVoltageDetect <= 1;
                tick(10);
                lowVoltageDetect <= 0;
            end
            default: ;
        endcase
    endtask
    task reportAndStop;
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        expQ.push_back(9'h000);
        tick(10);
        reset_n <= 1;
        waitRst(0, 6000);
        tick(4);
        $display("test initial release done");
        sawRst = 0;
        unmappedAddr <= 1;
        tick(3);
        unmappedAddr <= 0;
        n = $random(seed);
        lvPowerDisable <= n[0];
        lvResetDisable <= ~n[0];
        lowVoltageDetect <= 1;
        tick(3);
        lowVoltageDetect <= 0;
        lvPowerDisable <= 0;
        lvResetDisable <= 0;
        repeat (6) begin
            tick(1500 + ($random(seed) & 255));
            topAddrWrite <= 1;
            tick(1);
            topAddrWrite <= 0;
        end
        tick(2);
        `CHK(sawRst, 1'b0)
        $display("test quiet accesses done");
        periphWaitRun <= $random(seed);
        waitExec <= 1;
        tick(1);
        waitExec <= 0;
        tick(2);
        {cpuOr, busOr, perOr} = '0;
        repeat (12) begin
            @(posedge sys_clk);
            cpuOr |= cpuClock_r;
            busOr |= busClock_r;
            perOr |= periphClock_r;
        end
        `CHK({cpuOr, busOr, perOr}, {2'b01, periphWaitRun})
        wakeRequest <= 1;
        tick(1);
        wakeRequest <= 0;
        tick(8);
        $display("test wait done");
        for (int s = 1; s >= 0; s--) begin
            shortStopRecovery <= s[0];
            stopOscKeep <= s[0];
            topAddrWrite <= 1;
            tick(1);
            topAddrWrite <= 0;
            stopExec <= 1;
            tick(1);
            stopExec <= 0;
            tick(6);
            `CHK({cpuClock_r, busClock_r, genClockEnable_r}, {2'b00, s[0]})
            wakeRequest <= 1;
            tick(1);
            wakeRequest <= 0;
            n = 0;
            while (busClock_r !== 1 && n < 5000) begin
                @(posedge sys_clk);
                n++;
            end
            `CHK(n >= (s ? 28 : 4092) && n <= (s ? 40 : 4104), 1'b1)
            $display("test stop recovery %0d done", s);
        end
        for (int k = 0; k < 8; k++) begin
            eraseArm <= (k == 7);
            monitorStrap <= 1'b0;
            tick(1);
            eraseArm <= 0;
            por;
            monitorStrap <= (k == 3);
            expQ.push_back({k == 3 || k == 7, 8'h80 | (bitOf[k] < 0 ? 8'h00 : 8'h01 << bitOf[k])});
            fire(k);
            waitRst(1, 10000);
            waitRst(0, 6000);
            tick(4);
            $display("test source %0d done", k);
        end
        sawRst = 0;
        irqHighVoltage <= 1;
        tick(8300);
        `CHK(sawRst, 1'b0)
        $display("test watchdog disable done");
        reportAndStop;
    end
endmodule // tb_top
